// >>> src/rbp_breathing_pwm.sv
// Purpose: breathing pwm generator for an rgb led with an i2c register port
// Assumes: scl_in and sda_in are synchronous to clk_in; sda is open drain
// Notes:   i2c register writes are volatile and reset to stored values
//
// What this block does
// - each period counter pulses high for one clock per programmed period
// - the two pulses are xored and toggle a flip-flop on each event
// - offset pulse slips one clock per main period; gap sets pulse width
// - duty ramps up to full, back to minimum, and repeats unaided
// - three colour pwm inputs and one shared enable input
// - a colour drives only while enable and its pwm input are high
// - offset period at byte address C1, main period at C2
// - a new period value changes the ramp duration
// - written register values return to stored values on power-on reset
`timescale 1ns/1ps
`default_nettype none
module rbp_breathing_pwm (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic pwm_red_in,
  input  wire logic pwm_green_in,
  input  wire logic pwm_blue_in,
  input  wire logic out_enable_in,
  output logic      led_red_out,
  output logic      led_green_out,
  output logic      led_blue_out
);

  rbp_pkg::rbp_i2c_state_e state_q;
  logic                    scl_q;
  logic                    sda_q;
  logic [3:0]              bit_cnt_q;
  logic                    ack_phase_q;
  logic                    drive_ack_q;
  logic                    host_nack_q;
  logic [7:0]              shift_q;
  logic [7:0]              ptr_q;
  logic                    sda_oe_q;
  logic [7:0]              offset_period_q;
  logic [7:0]              main_period_q;
  logic                    main_pulse;
  logic                    offset_pulse;
  logic                    toggle_q;
  logic [2:0]              led_q;
  logic                    start_det;
  logic                    stop_det;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    byte_done;
  logic                    ack_end;
  logic                    addr_match;
  logic                    wr_en;
  logic                    in_read;
  logic [7:0]              rd_data;

  function automatic logic reg_sel(input logic [7:0] ptr, input logic [7:0] adr);
    reg_sel = (ptr == adr);
  endfunction

  // ----------------------------------------------------------------
  // bus line sampling and condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign start_det  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det   = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign byte_done  = scl_fall & (bit_cnt_q == rbp_pkg::RBP_BITS_PER_BYTE) & ~ack_phase_q;
  assign ack_end    = scl_fall & ack_phase_q;
  assign addr_match = (shift_q[7:1] == rbp_pkg::RBP_DEV_ADDR);
  assign in_read    = (state_q == rbp_pkg::RBP_ST_RDATA);
  assign wr_en      = byte_done & (state_q == rbp_pkg::RBP_ST_WDATA);

  // ----------------------------------------------------------------
  // transaction state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_q <= rbp_pkg::RBP_ST_IDLE;
    else if (start_det)
      state_q <= rbp_pkg::RBP_ST_ADDR;
    else if (stop_det)
      state_q <= rbp_pkg::RBP_ST_IDLE;
    else
    begin
      case (state_q)
        rbp_pkg::RBP_ST_IDLE:
          state_q <= rbp_pkg::RBP_ST_IDLE;
        rbp_pkg::RBP_ST_ADDR:
          if (byte_done)
            state_q <= !addr_match ? rbp_pkg::RBP_ST_IDLE :
                       shift_q[0]  ? rbp_pkg::RBP_ST_RDATA : rbp_pkg::RBP_ST_REG;
        rbp_pkg::RBP_ST_REG:
          if (byte_done)
            state_q <= rbp_pkg::RBP_ST_WDATA;
        rbp_pkg::RBP_ST_WDATA:
          state_q <= rbp_pkg::RBP_ST_WDATA;
        rbp_pkg::RBP_ST_RDATA:
          if (ack_end && host_nack_q)
            state_q <= rbp_pkg::RBP_ST_IDLE;
        default:
          state_q <= rbp_pkg::RBP_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit counting and acknowledge slot
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
    end
    else if (scl_rise && !ack_phase_q && bit_cnt_q != rbp_pkg::RBP_BITS_PER_BYTE)
      bit_cnt_q <= bit_cnt_q + 4'h1;
    else if (byte_done)
      ack_phase_q <= 1'b1;
    else if (ack_end)
    begin
      ack_phase_q <= 1'b0;
      bit_cnt_q   <= 4'h0;
    end
  end

  // a foreign address is never acknowledged, so the host sees a nack
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      drive_ack_q <= 1'b0;
    else if (start_det || stop_det || ack_end)
      drive_ack_q <= 1'b0;
    else if (byte_done)
      drive_ack_q <= (state_q == rbp_pkg::RBP_ST_ADDR && addr_match) ||
                     state_q == rbp_pkg::RBP_ST_REG || state_q == rbp_pkg::RBP_ST_WDATA;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      host_nack_q <= 1'b0;
    else if (byte_done || start_det)
      host_nack_q <= 1'b0;
    else if (scl_rise && ack_phase_q && !drive_ack_q)
      host_nack_q <= sda_in;
  end

  // ----------------------------------------------------------------
  // shift register and register pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      shift_q <= 8'h00;
    else if (in_read && ack_end)
      shift_q <= rd_data;
    else if (in_read && scl_fall && !ack_phase_q && bit_cnt_q != rbp_pkg::RBP_BITS_PER_BYTE)
      shift_q <= {shift_q[6:0], 1'b1};
    else if (!in_read && scl_rise && !ack_phase_q && bit_cnt_q != rbp_pkg::RBP_BITS_PER_BYTE)
      shift_q <= {shift_q[6:0], sda_in};
  end

  // pointer advances after each written byte and each acked read byte so consecutive bytes walk the map
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ptr_q <= 8'h00;
    else if (byte_done && state_q == rbp_pkg::RBP_ST_REG)
      ptr_q <= shift_q;
    else if (wr_en || (in_read && ack_end && !host_nack_q))
      ptr_q <= ptr_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // period registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      offset_period_q <= rbp_pkg::RBP_OFFSET_PERIOD_RST;
      main_period_q   <= rbp_pkg::RBP_MAIN_PERIOD_RST;
    end
    else if (wr_en)
    begin
      if (reg_sel(ptr_q, rbp_pkg::RBP_OFFSET_PERIOD_ADR))
        offset_period_q <= shift_q;
      if (reg_sel(ptr_q, rbp_pkg::RBP_MAIN_PERIOD_ADR))
        main_period_q <= shift_q;
    end
  end

  always_comb
  begin
    rd_data = rbp_pkg::RBP_UNMAPPED_READ;
    if (reg_sel(ptr_q, rbp_pkg::RBP_OFFSET_PERIOD_ADR))
      rd_data = offset_period_q;
    else if (reg_sel(ptr_q, rbp_pkg::RBP_MAIN_PERIOD_ADR))
      rd_data = main_period_q;
  end

  // open drain: only ever pull low
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sda_oe_q <= 1'b0;
    else
      sda_oe_q <= (ack_phase_q & drive_ack_q) | (in_read & ~ack_phase_q & ~shift_q[7]);
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe_q;

  // ----------------------------------------------------------------
  // breathing core
  // ----------------------------------------------------------------
  rbp_period_counter u_main_counter (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .period_in (main_period_q),
    .pulse_out (main_pulse)
  );

  rbp_period_counter u_offset_counter (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .period_in (offset_period_q),
    .pulse_out (offset_pulse)
  );

  // the xor acts as a toggle enable rather than a derived clock; the gap
  // between the drifting pulses grows then wraps, so the duty ramps by itself
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      toggle_q <= 1'b0;
    else if (main_pulse ^ offset_pulse)
      toggle_q <= ~toggle_q;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      led_q <= 3'h0;
    else
      led_q <= {3{toggle_q & out_enable_in}} & {pwm_red_in, pwm_green_in, pwm_blue_in};
  end

  assign led_red_out   = led_q[2];
  assign led_green_out = led_q[1];
  assign led_blue_out  = led_q[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_byte_then_ack;
    byte_done ##1 ack_phase_q;
  endsequence

  chk_xor_toggles: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (main_pulse ^ offset_pulse) |=> toggle_q != $past(toggle_q))
    else $error("toggle did not flip on xor event");

  chk_toggle_holds: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    !(main_pulse ^ offset_pulse) |=> $stable(toggle_q))
    else $error("toggle changed without xor event");

  chk_led_gating: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ##1 {led_red_out, led_green_out, led_blue_out} ==
        ({3{$past(toggle_q) & $past(out_enable_in)}} &
         {$past(pwm_red_in), $past(pwm_green_in), $past(pwm_blue_in)}))
    else $error("led outputs not gated by toggle, pwm and enable");

  chk_enable_dark: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    !out_enable_in |=> !led_red_out && !led_green_out && !led_blue_out)
    else $error("led driven while enable low");

  chk_reg_write: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_en && ptr_q == rbp_pkg::RBP_MAIN_PERIOD_ADR |=> main_period_q == $past(shift_q) && ptr_q == $past(ptr_q) + 8'h01)
    else $error("main period write not stored");

  chk_own_addr_ack: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    byte_done && state_q == rbp_pkg::RBP_ST_ADDR && addr_match && !start_det && !stop_det
      |=> ##1 sda_oe_out [*1] ##0 state_q != rbp_pkg::RBP_ST_IDLE)
    else $error("own address not acknowledged");

  chk_foreign_addr: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    byte_done && state_q == rbp_pkg::RBP_ST_ADDR && !addr_match && !start_det && !stop_det
      |=> state_q == rbp_pkg::RBP_ST_IDLE && !drive_ack_q)
    else $error("foreign address answered");

  chk_stop_idle: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    stop_det && !start_det |=> state_q == rbp_pkg::RBP_ST_IDLE && !ack_phase_q)
    else $error("stop did not end the transaction");

  chk_ack_slot: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    s_byte_then_ack |-> bit_cnt_q == rbp_pkg::RBP_BITS_PER_BYTE)
    else $error("ack slot opened off the ninth clock");

endmodule
`default_nettype wire

// >>> pkg/rbp_pkg.sv
// Purpose: shared constants and types of the rgb breathing pwm block
// Assumes: 200 MHz system clock, i2c pins sampled as synchronous inputs
// Notes:   register reset values are the stored configuration
package rbp_pkg;

  // ----------------------------------------------------------------
  // i2c target addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] RBP_DEV_ADDR          = 7'h00;
  localparam logic [7:0] RBP_OFFSET_PERIOD_ADR = 8'hC1;
  localparam logic [7:0] RBP_MAIN_PERIOD_ADR   = 8'hC2;
  localparam logic [7:0] RBP_UNMAPPED_READ     = 8'h00;
  localparam logic [3:0] RBP_BITS_PER_BYTE     = 4'h8;

  // ----------------------------------------------------------------
  // stored configuration, restored by every power-on reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RBP_OFFSET_PERIOD_RST = 8'h15;
  localparam logic [7:0] RBP_MAIN_PERIOD_RST   = 8'h14;

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  localparam logic [7:0] RBP_CNT_TERMINAL      = 8'h00;
  localparam logic [8:0] RBP_GAP_ONE           = 9'h001;

  // ----------------------------------------------------------------
  // i2c transaction states, gray along idle-addr-reg-wdata
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RBP_ST_IDLE  = 3'h0,
    RBP_ST_ADDR  = 3'h1,
    RBP_ST_REG   = 3'h3,
    RBP_ST_WDATA = 3'h2,
    RBP_ST_RDATA = 3'h6
  } rbp_i2c_state_e;

endpackage

// >>> src/rbp_period_counter.sv
// Purpose: programmable period counter emitting a one-cycle pulse
// Assumes: period_in is the register value; true period is value plus one
// Notes:   a value of zero gives a pulse on every cycle
`timescale 1ns/1ps
`default_nettype none
module rbp_period_counter (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] period_in,
  output logic            pulse_out
);

  logic [7:0] cnt_q;
  logic       pulse_q;

  // ----------------------------------------------------------------
  // down counter, reloads after reaching zero
  // ----------------------------------------------------------------
  // a new period is only picked up at reload, so a write never truncates
  // the running period
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_q <= rbp_pkg::RBP_CNT_TERMINAL;
    else if (cnt_q == rbp_pkg::RBP_CNT_TERMINAL)
      cnt_q <= period_in;
    else
      cnt_q <= cnt_q - 8'h01;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pulse_q <= 1'b0;
    else
      pulse_q <= (cnt_q == rbp_pkg::RBP_CNT_TERMINAL);
  end

  assign pulse_out = pulse_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [8:0] gap_q;
  logic [7:0] per_q;
  logic       seen_q;
  logic       chg_q;

  localparam logic [8:0] RBP_GAP_LOCAL = 9'h000;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gap_q  <= rbp_pkg::RBP_GAP_ONE;
      per_q  <= 8'h00;
      seen_q <= 1'b0;
      chg_q  <= 1'b1;
    end
    else
    begin
      per_q <= period_in;
      gap_q <= pulse_q ? rbp_pkg::RBP_GAP_ONE : gap_q + 9'h001;
      if (pulse_q)
        seen_q <= 1'b1;
      chg_q <= pulse_q ? (period_in != per_q) : (chg_q | (period_in != per_q));
    end
  end

  chk_pulse_single: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    pulse_q && period_in != 8'h00 && per_q == period_in |=> !pulse_q)
    else $error("period pulse lasted more than one cycle");

  // compare with the value that was reloaded; a write landing on the reload
  // edge is not yet in the change history
  chk_pulse_spacing: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    pulse_q && seen_q && !chg_q && gap_q != RBP_GAP_LOCAL |-> gap_q == {1'b0, per_q} + 9'h001)
    else $error("period pulse spacing differs from programmed period");

endmodule
`default_nettype wire

// >>> tb/rbp_i2c_host.sv
// Purpose: i2c host model that programs the breathing pwm registers
// Assumes: every scl phase lasts four system clocks; sda is open drain
// Notes:   sda_low_out high pulls the line low, low releases it
`timescale 1ns/1ps
`default_nettype none
module rbp_i2c_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus phases, changed just after a rising edge
  // ----------------------------------------------------------------
  task automatic half(input logic c, input logic d);
    @(posedge clk_in);
    scl_out     <= c;
    sda_low_out <= d;
    repeat (3) @(posedge clk_in);
  endtask

  // sda only moves while scl is low, except for start and stop
  task automatic start();
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
    half(1'b1, 1'b1);
    half(1'b0, 1'b1);
  endtask

  task automatic stop();
    half(1'b0, 1'b1);
    half(1'b1, 1'b1);
    half(1'b1, 1'b0);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      half(1'b0, ~b[i]);
      half(1'b1, ~b[i]);
    end
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
    ack = ~sda_in;
  endtask

  // a single byte is read, so the host always answers with a nack
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      half(1'b0, 1'b0);
      half(1'b1, 1'b0);
      b[i] = sda_in;
    end
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // register transfers
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
                           input logic [7:0] d, output logic [2:0] acks);
    start();
    put_byte({dev, 1'b0}, acks[2]);
    put_byte(ra, acks[1]);
    put_byte(d, acks[0]);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    start();
    put_byte({rbp_pkg::RBP_DEV_ADDR, 1'b0}, a);
    put_byte(ra, a);
    start();
    put_byte({rbp_pkg::RBP_DEV_ADDR, 1'b1}, a);
    get_byte(d);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the rgb breathing pwm block
// Assumes: 200 MHz clock; host model owns scl and its half of sda
// Notes:   outputs are sampled on the falling edge to stay clear of updates
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  logic       clk;
  logic       arst_n;
  logic       scl;
  logic       host_low;
  logic       sda_o;
  logic       sda_oe;
  logic       pwm_r;
  logic       pwm_g;
  logic       pwm_b;
  logic       oe;
  logic       led_r;
  logic       led_g;
  logic       led_b;
  wire        sda_line;
  int         bad_count;
  int         tests_run;

  // open-drain wire with pull-up
  assign sda_line = ~(host_low | (sda_oe & ~sda_o));

  rbp_i2c_host host (.clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_low));

  rbp_breathing_pwm dut (
    .clk_in(clk), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .pwm_red_in(pwm_r),
    .pwm_green_in(pwm_g), .pwm_blue_in(pwm_b), .out_enable_in(oe),
    .led_red_out(led_r), .led_green_out(led_g), .led_blue_out(led_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(ra, d);
    `CHK(d, exp)
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, input logic [2:0] exp);
    logic [2:0] a;
    host.write_reg(dev, ra, d, a);
    `CHK(a, exp)
  endtask

  // high runs grow by one clock each main period of 21 clocks
  task automatic runs_check();
    int t;
    int len;
    int plen;
    plen = 0;
    for (int k = 1; k <= 4; k++)
    begin
      t = 0;
      while (led_r !== 1'b1 && t < 200)
      begin
        @(negedge clk);
        t++;
      end
      if (t >= 200)
      begin
        bad_count++;
        stop_test();
      end
      len = 0;
      while (led_r === 1'b1 && len < 200)
      begin
        @(negedge clk);
        len++;
      end
      `CHK(len, k)
      if (k > 1)
        `CHK(plen + t, 21)
      plen = len;
    end
  endtask

  // the pattern must repeat by itself with period n and not be flat
  task automatic repeat_check(input int n);
    logic [1023:0] a;
    int            ones;
    ones = 0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      a[i] = led_r;
      ones += int'(led_r);
    end
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      `CHK(led_r, a[i])
    end
    `CHK(ones > 0 && ones < n, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0] seen;
    arst_n    = 1'b0;
    pwm_r     = 1'b1;
    pwm_g     = 1'b1;
    pwm_b     = 1'b1;
    oe        = 1'b1;
    bad_count = 0;
    tests_run = 0;
    do_reset();
    runs_check();
    repeat_check(924);
    rd(rbp_pkg::RBP_OFFSET_PERIOD_ADR, 8'h15);
    rd(rbp_pkg::RBP_MAIN_PERIOD_ADR, 8'h14);
    wr(7'h5A, rbp_pkg::RBP_MAIN_PERIOD_ADR, 8'h01, 3'h0);
    wr(rbp_pkg::RBP_DEV_ADDR, rbp_pkg::RBP_MAIN_PERIOD_ADR, 8'h04, 3'h7);
    wr(rbp_pkg::RBP_DEV_ADDR, rbp_pkg::RBP_OFFSET_PERIOD_ADR, 8'h05, 3'h7);
    rd(rbp_pkg::RBP_MAIN_PERIOD_ADR, 8'h04);
    rd(rbp_pkg::RBP_OFFSET_PERIOD_ADR, 8'h05);
    rd(8'hC3, rbp_pkg::RBP_UNMAPPED_READ);
    repeat (20) @(posedge clk);
    repeat_check(60);
    for (int m = 0; m < 16; m++)
    begin
      @(posedge clk);
      oe    <= m[3];
      pwm_r <= m[2];
      pwm_g <= m[1];
      pwm_b <= m[0];
      seen = 3'h0;
      repeat (2) @(negedge clk);
      repeat (62)
      begin
        @(negedge clk);
        seen |= {led_r, led_g, led_b};
      end
      `CHK(seen, {3{m[3]}} & 3'(m[2:0]))
    end
    do_reset();
    runs_check();
    rd(rbp_pkg::RBP_OFFSET_PERIOD_ADR, 8'h15);
    stop_test();
  end
endmodule
`default_nettype wire
